// *** shared/epg_map.vh ***
// Purpose: register offsets, field positions and reset values of the PWM block
// Assumes: 8-bit registers at byte offsets on the controller internal bus
// Notes: definitions only
`ifndef EPG_MAP_VH
`define EPG_MAP_VH
`define EPG_OFS_G0_DIV 8'h00
`define EPG_OFS_CYCLE 8'h01
`define EPG_OFS_DUTY0 8'h02
`define EPG_OFS_DUTY1 8'h03
`define EPG_OFS_DUTY2 8'h04
`define EPG_OFS_DUTY3 8'h05
`define EPG_OFS_DUTY4 8'h06
`define EPG_OFS_DUTY5 8'h07
`define EPG_OFS_DUTY6 8'h08
`define EPG_OFS_DUTY7 8'h09
`define EPG_OFS_INVERT 8'h0A
`define EPG_OFS_FREQ_SEL 8'h0B
`define EPG_OFS_SRC_LOW 8'h0C
`define EPG_OFS_SRC_HIGH 8'h0D
`define EPG_OFS_ZONE_IE 8'h23
`define EPG_OFS_G1_LOW 8'h27
`define EPG_OFS_G1_HIGH 8'h28
`define EPG_OFS_G2_LOW 8'h2B
`define EPG_OFS_G2_HIGH 8'h2C
`define EPG_OFS_G3_LOW 8'h2D
`define EPG_OFS_G3_HIGH 8'h2E
`define EPG_RST_G0_DIV 8'h00
`define EPG_RST_CYCLE 8'hFF
`define EPG_RST_DUTY 8'h00
`define EPG_RST_INVERT 8'h00
`define EPG_RST_FREQ_SEL 4'h0
`define EPG_RST_SRC_LOW 8'h00
`define EPG_RST_SRC_HIGH 8'h55
`define EPG_RST_ZONE_IE 8'h00
`define EPG_RST_GDIV 8'h00
`define EPG_CLK_ENABLE_BIT 7
`define EPG_FREQ_SEL_W 4
`endif

// *** core/epg_pwm.v ***
// Purpose: eight-channel 8-bit PWM generator with four prescaler groups
// Assumes: i_sys_clk 20 MHz; i_slow_tick is a one-cycle pulse at 32.768 kHz
// Notes: fast source is the system clock halved (10 MHz)
// Function
// [RULE1] Group 0 divides by eight-bit value plus one
// [RULE2] Cycle length divides working clock by value+1
// [RULE3] Software changes dividers only while inhibited
// [RULE4] Duty value sets high periods per cycle
// [RULE5] Duty above cycle length holds output low
// [RULE6] Duty equal cycle length holds output high
// [RULE7] One invert bit per channel, reset zero
// [RULE8] Per-group select: 32 kHz or 10 MHz
// [RULE9] Four groups; groups 1-3 use 16-bit dividers
// [RULE10] Channels 0-3 two-bit group select, reset 00
// [RULE11] Channels 4-7 two-bit group select, reset 01
// [RULE12] Clock-enable low stops; output equals invert bit
// [RULE13] Down-counter reloads at zero; high when duty>count
// [RULE14] Zero duty, no invert gives constant low
// [RULE15] Duty changes reach comparators only at cycle boundaries; the code also loads them while inhibited
`include "epg_map.vh"
`timescale 1ns/1ps
`default_nettype none
module epg_pwm #(
   parameter NUM_CH = 8
) (
   input wire i_sys_clk,
   input wire i_srst,
   input wire i_slow_tick,
   input wire [7:0] i_addr,
   input wire i_wr,
   input wire [7:0] i_wdata,
   input wire i_rd,
   output reg [7:0] o_rdata,
   output reg [NUM_CH-1:0] o_pwm
);
   // Software-visible registers
   reg [7:0] g0_div_q;
   reg [7:0] cycle_q;
   reg [7:0] duty_q [0:NUM_CH-1];
   reg [7:0] invert_q;
   reg [3:0] freq_sel_q;
   reg [15:0] src_sel_q;
   reg [7:0] zone_ie_q;
   reg [15:0] gdiv_q [1:3];
   reg [7:0] rdata_d;

   // Timing chain: fast phase, prescalers, cycle counters
   reg fast_ph_q;
   reg [15:0] pre_cnt_q [0:3];
   reg [7:0] cyc_cnt_q [0:3];
   wire [3:0] wtick;
   reg [15:0] gdiv_w [0:3];

   // Output stage
   wire [NUM_CH-1:0] level_w;
   reg [NUM_CH-1:0] pwm_d;
   wire run;
   integer k;

   // Clock-enable bit low means inhibit: no working clock anywhere
   assign run = zone_ie_q[`EPG_CLK_ENABLE_BIT];

   always @*
   begin
      gdiv_w[0] = {8'h00, g0_div_q}; // RULE1
      gdiv_w[1] = gdiv_q[1]; // RULE9
      gdiv_w[2] = gdiv_q[2];
      gdiv_w[3] = gdiv_q[3];
   end

   // Register writes; dividers are expected to change only while inhibited
   always @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         g0_div_q <= `EPG_RST_G0_DIV;
         cycle_q <= `EPG_RST_CYCLE; // RULE2
         invert_q <= `EPG_RST_INVERT; // RULE7
         freq_sel_q <= `EPG_RST_FREQ_SEL; // RULE8
         src_sel_q <= {`EPG_RST_SRC_HIGH, `EPG_RST_SRC_LOW}; // RULE10 RULE11
         zone_ie_q <= `EPG_RST_ZONE_IE;
         for (k = 0; k < NUM_CH; k = k + 1)
            duty_q[k] <= `EPG_RST_DUTY; // RULE4
         for (k = 1; k < 4; k = k + 1)
            gdiv_q[k] <= {`EPG_RST_GDIV, `EPG_RST_GDIV};
      end
      else if (i_wr)
      begin
         case (i_addr)
            `EPG_OFS_DUTY0: duty_q[0] <= i_wdata;
            `EPG_OFS_DUTY1: duty_q[1] <= i_wdata;
            `EPG_OFS_DUTY2: duty_q[2] <= i_wdata;
            `EPG_OFS_DUTY3: duty_q[3] <= i_wdata;
            `EPG_OFS_DUTY4: duty_q[4] <= i_wdata;
            `EPG_OFS_DUTY5: duty_q[5] <= i_wdata;
            `EPG_OFS_DUTY6: duty_q[6] <= i_wdata;
            `EPG_OFS_DUTY7: duty_q[7] <= i_wdata;
            `EPG_OFS_G0_DIV: g0_div_q <= i_wdata; // RULE3
            `EPG_OFS_CYCLE: cycle_q <= i_wdata; // RULE3
            `EPG_OFS_INVERT: invert_q <= i_wdata;
            `EPG_OFS_FREQ_SEL: freq_sel_q <= i_wdata[3:0];
            `EPG_OFS_SRC_LOW: src_sel_q[7:0] <= i_wdata;
            `EPG_OFS_SRC_HIGH: src_sel_q[15:8] <= i_wdata;
            `EPG_OFS_ZONE_IE: zone_ie_q <= i_wdata;
            `EPG_OFS_G1_LOW: gdiv_q[1][7:0] <= i_wdata;
            `EPG_OFS_G1_HIGH: gdiv_q[1][15:8] <= i_wdata;
            `EPG_OFS_G2_LOW: gdiv_q[2][7:0] <= i_wdata;
            `EPG_OFS_G2_HIGH: gdiv_q[2][15:8] <= i_wdata;
            `EPG_OFS_G3_LOW: gdiv_q[3][7:0] <= i_wdata;
            `EPG_OFS_G3_HIGH: gdiv_q[3][15:8] <= i_wdata;
            default: ;
         endcase
      end
   end

   // Read mux; unmapped offsets and reserved bits read zero
   always @*
   begin
      rdata_d = 8'h00;
      case (i_addr)
         `EPG_OFS_G0_DIV: rdata_d = g0_div_q;
         `EPG_OFS_CYCLE: rdata_d = cycle_q;
         `EPG_OFS_DUTY0: rdata_d = duty_q[0];
         `EPG_OFS_DUTY1: rdata_d = duty_q[1];
         `EPG_OFS_DUTY2: rdata_d = duty_q[2];
         `EPG_OFS_DUTY3: rdata_d = duty_q[3];
         `EPG_OFS_DUTY4: rdata_d = duty_q[4];
         `EPG_OFS_DUTY5: rdata_d = duty_q[5];
         `EPG_OFS_DUTY6: rdata_d = duty_q[6];
         `EPG_OFS_DUTY7: rdata_d = duty_q[7];
         `EPG_OFS_INVERT: rdata_d = invert_q;
         `EPG_OFS_FREQ_SEL: rdata_d = {4'h0, freq_sel_q};
         `EPG_OFS_SRC_LOW: rdata_d = src_sel_q[7:0];
         `EPG_OFS_SRC_HIGH: rdata_d = src_sel_q[15:8];
         `EPG_OFS_ZONE_IE: rdata_d = zone_ie_q;
         `EPG_OFS_G1_LOW: rdata_d = gdiv_q[1][7:0];
         `EPG_OFS_G1_HIGH: rdata_d = gdiv_q[1][15:8];
         `EPG_OFS_G2_LOW: rdata_d = gdiv_q[2][7:0];
         `EPG_OFS_G2_HIGH: rdata_d = gdiv_q[2][15:8];
         `EPG_OFS_G3_LOW: rdata_d = gdiv_q[3][7:0];
         `EPG_OFS_G3_HIGH: rdata_d = gdiv_q[3][15:8];
         default: rdata_d = 8'h00;
      endcase
   end

   // Port flop holds the last read until the next one
   always @(posedge i_sys_clk)
   begin
      if (i_srst)
         o_rdata <= 8'h00;
      else if (i_rd)
         o_rdata <= rdata_d;
   end

   // 10 MHz source as every second system clock
   always @(posedge i_sys_clk)
   begin
      if (i_srst)
         fast_ph_q <= 1'b0;
      else
         fast_ph_q <= ~fast_ph_q;
   end

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : grp
         wire src_tick;
         reg [15:0] pre_cnt_d;
         reg [7:0] cyc_cnt_d;
         assign src_tick = freq_sel_q[g] ? fast_ph_q : i_slow_tick; // RULE8
         assign wtick[g] = run && src_tick && (pre_cnt_q[g] == gdiv_w[g]);

         // Prescaler divides by value plus one; held clear while inhibited
         always @*
         begin
            pre_cnt_d = pre_cnt_q[g];
            if (!run)
               pre_cnt_d = 16'h0000; // RULE12
            else if (src_tick)
            begin
               if (pre_cnt_q[g] == gdiv_w[g])
                  pre_cnt_d = 16'h0000; // RULE1 RULE9
               else
                  pre_cnt_d = pre_cnt_q[g] + 16'h0001;
            end
         end

         // Cycle down-counter per group; parked at reload value while inhibited
         always @*
         begin
            cyc_cnt_d = cyc_cnt_q[g];
            if (!run)
               cyc_cnt_d = cycle_q;
            else if (wtick[g])
            begin
               if (cyc_cnt_q[g] == 8'h00)
                  cyc_cnt_d = cycle_q; // RULE2 RULE13
               else
                  cyc_cnt_d = cyc_cnt_q[g] - 8'h01; // RULE13
            end
         end

         always @(posedge i_sys_clk)
         begin
            if (i_srst)
            begin
               pre_cnt_q[g] <= 16'h0000;
               cyc_cnt_q[g] <= `EPG_RST_CYCLE;
            end
            else
            begin
               pre_cnt_q[g] <= pre_cnt_d;
               cyc_cnt_q[g] <= cyc_cnt_d;
            end
         end
      end
   endgenerate

   genvar c;
   generate
      for (c = 0; c < NUM_CH; c = c + 1)
      begin : ch
         wire [1:0] sel;
         reg [7:0] duty_act_q;
         reg level;
         assign sel = src_sel_q[2*c+1:2*c]; // RULE10 RULE11

         // Shadow duty updates only at a cycle boundary or while inhibited, to avoid runt pulses
         always @(posedge i_sys_clk)
         begin
            if (i_srst)
               duty_act_q <= `EPG_RST_DUTY;
            else if (!run || (wtick[sel] && cyc_cnt_q[sel] == 8'h00))
               duty_act_q <= duty_q[c]; // RULE15
         end
         always @*
         begin
            if (duty_act_q > cycle_q)
               level = 1'b0; // RULE5
            else if (duty_act_q == cycle_q)
               level = 1'b1; // RULE6
            else
               level = duty_act_q > cyc_cnt_q[sel]; // RULE4 RULE13 RULE14
         end
         assign level_w[c] = level;
      end
   endgenerate

   // Inhibit parks every output at its invert bit
   always @*
   begin
      pwm_d = invert_q[NUM_CH-1:0]; // RULE12
      if (run)
         pwm_d = level_w ^ invert_q[NUM_CH-1:0]; // RULE7
   end

   // One flop stage for all outputs, so pins never see comparator glitches
   always @(posedge i_sys_clk)
   begin
      if (i_srst)
         o_pwm <= {NUM_CH{1'b0}};
      else
         o_pwm <= pwm_d;
   end
endmodule // epg_pwm
`default_nettype wire

// *** tb/epg_pwm_monitor.sv ***
// Purpose: port checker for the PWM block
// Assumes: 63 idle bus cycles settle outputs
// Notes: shadows follow register writes
`timescale 1ns/1ps
`default_nettype none
module epg_mon #(parameter NUM_CH = 8) (
   input wire logic i_sys_clk,
   input wire logic i_srst,
   input wire logic [7:0] i_addr,
   input wire logic i_wr,
   input wire logic [7:0] i_wdata,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   input wire logic [NUM_CH-1:0] o_pwm
);
   logic en_q;
   logic [7:0] inv_q, cyc_q, gt, eq, zm, lv;
   logic [7:0] dty_q [8];
   logic [5:0] st_q;
   wire qt = st_q == 6'h3F;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_srst);
   always_ff @(posedge i_sys_clk)
   begin
      st_q <= (i_srst || i_wr) ? 6'h00 : st_q + 6'(!qt);
      if (i_srst)
      begin
         en_q <= 1'b0;
         inv_q <= 8'h00;
         cyc_q <= 8'hFF;
         dty_q <= '{default: 8'h00};
      end
      else if (i_wr)
         case (i_addr)
            8'h01: cyc_q <= i_wdata;
            8'h0A: inv_q <= i_wdata;
            8'h23: en_q <= i_wdata[7];
            default: if (i_addr inside {[2:9]}) dty_q[3'(i_addr - 8'h02)] <= i_wdata;
         endcase
   end
   always_comb
      for (int k = 0; k < 8; k++)
      begin
         gt[k] = dty_q[k] > cyc_q;
         eq[k] = dty_q[k] == cyc_q;
         zm[k] = dty_q[k] == 8'h00 && !eq[k];
      end
   assign lv = 8'(o_pwm) ^ inv_q;
   property p_rst; disable iff (1'b0) i_srst |=> o_pwm == '0; endproperty
   a_rst: assert property (p_rst) else $error("reset level");
   property p_cyc; $past(i_rd) && $past(i_addr) == 8'h01 |-> o_rdata == cyc_q; endproperty
   a_cyc: assert property (p_cyc) else $error("cycle read");
   property p_fsr; $past(i_rd) && $past(i_addr) == 8'h0B |-> o_rdata[7:4] == 4'h0; endproperty
   a_fsr: assert property (p_fsr) else $error("select read");
   property p_dty;
      $past(i_rd) && $past(i_addr) inside {[2:9]} |-> o_rdata == dty_q[3'($past(i_addr) - 8'h02)];
   endproperty
   a_dty: assert property (p_dty) else $error("duty read");
   property p_inh; qt && !en_q |-> lv == 8'h00; endproperty
   a_inh: assert property (p_inh) else $error("inhibit level");
   property p_gt; qt |-> (lv & gt) == 8'h00; endproperty
   a_gt: assert property (p_gt) else $error("duty above cycle");
   property p_eq; qt && en_q |-> (lv & eq) == eq; endproperty
   a_eq: assert property (p_eq) else $error("duty equal cycle");
   property p_z; qt |-> (lv & zm) == 8'h00; endproperty
   a_z: assert property (p_z) else $error("zero duty");
   c_run: cover property (qt && en_q && eq != 8'h00);
   c_inh: cover property (qt && !en_q && inv_q != 8'h00);
   c_rd: cover property ($past(i_rd) && $past(i_addr) == 8'h04);
endmodule // epg_mon
bind epg_pwm epg_mon #(.NUM_CH(NUM_CH)) u_mon (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
   .i_addr(i_addr), .i_wr(i_wr), .i_wdata(i_wdata), .i_rd(i_rd), .o_rdata(o_rdata),
   .o_pwm(o_pwm));
`default_nettype wire

// *** tb/epg_load.sv ***
// Purpose: load model counting PWM high time
// Assumes: sampled on the system clock
// Notes: rising edges counted on output 0 only
`timescale 1ns/1ps
`default_nettype none
module epg_load (
   input wire logic i_clk,
   input wire logic i_clear,
   input wire logic [7:0] i_drive,
   output var logic [15:0] o_high [8],
   output var logic [15:0] o_rises
);
   logic prev_q;
   always_ff @(posedge i_clk)
   begin
      prev_q <= i_drive[0];
      o_rises <= i_clear ? 16'h0000 : o_rises + 16'(i_drive[0] && !prev_q);
      for (int k = 0; k < 8; k++)
         o_high[k] <= i_clear ? 16'h0000 : o_high[k] + 16'(i_drive[k]);
   end
endmodule // epg_load
`default_nettype wire

// *** tb/tb_epg_pwm.sv ***
// Purpose: register and output bench for the PWM block
// Assumes: all groups on the fast source in the first run; group 2 on the slow tick in the second
// Notes: slow tick shortened to one pulse every 32 clocks; the second run's channel 2 count depends on it
`timescale 1ns/1ps
`default_nettype none
`define EPG_CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
   $display("Error %s expected %0h seen %0h", n, e, g); end end
module tb_epg_pwm;
   logic clk = 1'b0, rst = 1'b1, tk = 1'b0, wr = 1'b0, rd = 1'b0, clr = 1'b1;
   logic [7:0] ad = 8'h00, wd = 8'h00, rdat, pwm;
   logic [15:0] hi [8];
   logic [15:0] ris;
   logic [4:0] tc = 5'h00;
   int error_cnt = 0, check_count = 0;
   logic [7:0] rv [14] = '{0, 8'hFF, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 8'h55};
   logic [15:0] cf [7] = '{16'h0103, 16'h0201, 16'h0303, 16'h0405, 16'h0602, 16'h0A00, 16'h2380};
   logic [15:0] ex [8] = '{16'h0014, 16'h0050, 0, 0, 16'h0028, 0, 0, 0};
   epg_pwm dut (.i_sys_clk(clk), .i_srst(rst), .i_slow_tick(tk), .i_addr(ad), .i_wr(wr),
      .i_wdata(wd), .i_rd(rd), .o_rdata(rdat), .o_pwm(pwm));
   epg_load ld (.i_clk(clk), .i_clear(clr), .i_drive(pwm), .o_high(hi), .o_rises(ris));
   initial forever #25 clk = !clk;
   always @(posedge clk)
   begin
      tc <= tc + 5'h01;
      tk <= tc == 5'h00;
   end
   task automatic w(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      ad <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic r(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      ad <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      #1 `EPG_CHK("rdata", e, rdat)
   endtask
   task automatic win(input int n);
      @(posedge clk);
      clr <= 1'b0;
      repeat (n) @(posedge clk);
      clr <= 1'b1;
      #1;
   endtask
   task automatic close_out;
      $display("errors %0d checks %0d", error_cnt, check_count);
      if (error_cnt == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      for (int k = 0; k < 14; k++) r(8'(k), rv[k]);
      r(8'h0E, 8'h00);
      w(8'h0B, 8'hFF);
      r(8'h0B, 8'h0F);
      w(8'h0A, 8'hA5);
      repeat (4) @(posedge clk);
      #1 `EPG_CHK("idle", 8'hA5, pwm)
      foreach (cf[k]) w(cf[k][15:8], cf[k][7:0]);
      repeat (70) @(posedge clk);
      win(80);
      foreach (hi[k]) `EPG_CHK("high", ex[k], hi[k])
      `EPG_CHK("rises", 16'h000A, ris)
      w(8'h23, 8'h00);
      w(8'h00, 8'h01);
      w(8'h0A, 8'h01);
      w(8'h0C, 8'h20);
      w(8'h0B, 8'h0B);
      w(8'h04, 8'h02);
      w(8'h2D, 8'h3C);
      w(8'h2E, 8'hC3);
      r(8'h2D, 8'h3C);
      r(8'h2E, 8'hC3);
      r(8'h23, 8'h00);
      w(8'h23, 8'h80);
      repeat (70) @(posedge clk);
      win(256);
      `EPG_CHK("high0", 16'h00C0, hi[0])
      `EPG_CHK("high2", 16'h0080, hi[2])
      `EPG_CHK("rises", 16'h0010, ris)
      close_out;
   end
   initial
   begin
      repeat (5000) @(posedge clk);
      error_cnt++;
      close_out;
   end
endmodule // tb_epg_pwm
`default_nettype wire
